// File: logic/idg_index_irq_gate.sv
`timescale 1ns/1ps
`default_nettype none
module idg_index_irq_gate
	import idg_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Instruction issue, one cycle each
	input wire logic op_valid,
	input wire logic [IDG_OP_W-1:0] op_code,
	// Index register load from core
	input wire logic index_load,
	input wire logic [IDG_IDX_W-1:0] index_load_val,
	// Carry passthrough
	input wire logic carry_in,
	// Results
	output logic [IDG_IDX_W-1:0] index_reg,
	output logic skip_next,
	output logic master_irq_enable_flag,
	output logic irq_accept_en,
	output logic wdt_stop_armed,
	output logic wdt_halt,
	output logic wdt_restart_pulse,
	output logic carry_flag
);
	// ==========================================
	// Instruction decode
	// Each strobe is high only in the cycle its word is issued
	logic is_dec; // Decrement index word
	logic is_dis; // Interrupt disable word
	logic is_en; // Interrupt enable word
	logic is_arm; // Watchdog stop arm word
	logic is_rst; // Watchdog restart word

	// Full-word compares: unknown words match nothing and are ignored
	assign is_dec = op_valid && (op_code == IDG_OP_DEC_INDEX);
	assign is_dis = op_valid && (op_code == IDG_OP_IRQ_DIS);
	assign is_en = op_valid && (op_code == IDG_OP_IRQ_EN);
	assign is_arm = op_valid && (op_code == IDG_OP_WDT_ARM);
	assign is_rst = op_valid && (op_code == IDG_OP_WDT_RESTART);

	// ==========================================
	// State and next values
	// Index path
	logic [IDG_IDX_W-1:0] idx_r, idx_nxt; // Index register
	logic skip_r, skip_nxt; // Skip request, one cycle
	// Interrupt gate
	logic ie_r, ie_nxt; // Master interrupt enable flag
	logic acc_r, acc_nxt; // Interrupt acceptance, lags flag on disable
	// Watchdog control
	logic arm_r, arm_nxt; // Watchdog stop armed, sticky
	logic halt_r, halt_nxt; // Watchdog halted, sticky
	logic rp_r, rp_nxt; // Plain restart pulse, one cycle
	// Carry and helper
	logic cy_r, cy_nxt; // Carry copy, never changed here
	logic [IDG_IDX_W-1:0] dec_val; // Index minus one, wraps modulo sixteen

	// ==========================================
	// Next-state logic
	// Defaults hold every level except acceptance and carry, and drop every pulse
	always_comb begin
		// Helper: index minus one
		dec_val = idx_r - IDG_IDX_ONE;
		idx_nxt = idx_r;
		skip_nxt = 1'b0;
		ie_nxt = ie_r;
		arm_nxt = arm_r;
		halt_nxt = halt_r;
		rp_nxt = 1'b0;
		// Carry is only copied through, none of these words writes it
		cy_nxt = carry_in;
		// Acceptance follows the flag one cycle late
		acc_nxt = ie_r;
		// Core load of the index, overridden by a decrement below
		if (index_load) begin
			idx_nxt = index_load_val;
		end
		// Decrement; a wrap to fifteen asks the fetch unit to skip
		if (is_dec) begin
			idx_nxt = dec_val;
			skip_nxt = (dec_val == IDG_IDX_WRAP);
		end
		// Disable clears the flag; acceptance still sees the old flag
		if (is_dis) begin
			ie_nxt = 1'b0;
		end
		// Enable sets flag and acceptance together
		if (is_en) begin
			ie_nxt = 1'b1;
			acc_nxt = 1'b1;
		end
		// Arm stays set until reset
		if (is_arm) begin
			arm_nxt = 1'b1;
		end
		// Restart halts the watchdog once armed, otherwise it pulses
		if (is_rst) begin
			if (arm_r) begin
				// Armed: stop the watchdog, no restart pulse
				halt_nxt = 1'b1;
			end else begin
				// Not armed: ordinary restart
				rp_nxt = 1'b1;
			end
		end
	end

	// ==========================================
	// State registers
	// Asynchronous reset loads constants only
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			// Every register to its idle value
			idx_r <= IDG_IDX_RESET;
			skip_r <= 1'b0;
			ie_r <= IDG_IRQ_EN_RESET;
			acc_r <= IDG_IRQ_EN_RESET;
			arm_r <= 1'b0;
			halt_r <= 1'b0;
			rp_r <= 1'b0;
			cy_r <= 1'b0;
		end else begin
			// Register every next value
			idx_r <= idx_nxt;
			skip_r <= skip_nxt;
			ie_r <= ie_nxt;
			acc_r <= acc_nxt;
			arm_r <= arm_nxt;
			halt_r <= halt_nxt;
			rp_r <= rp_nxt;
			cy_r <= cy_nxt;
		end
	end

	// ==========================================
	// Outputs
	// Every output is a flip-flop of its own
	// Index path
	assign index_reg = idx_r;
	assign skip_next = skip_r;
	// Interrupt gate
	assign master_irq_enable_flag = ie_r;
	assign irq_accept_en = acc_r;
	// Watchdog control
	assign wdt_stop_armed = arm_r;
	assign wdt_halt = halt_r;
	assign wdt_restart_pulse = rp_r;
	// Carry
	assign carry_flag = cy_r;

	// ==========================================
	// Assertions
	// Decrement from zero lands on fifteen and skips
	property p_dec_wrap;
		@(posedge clk_sys) disable iff (reset)
		is_dec && !index_load && (idx_r == IDG_IDX_RESET) |=> (idx_r == IDG_IDX_WRAP) && skip_r;
	endproperty
	a_dec_wrap: assert property (p_dec_wrap) else $error("no wrap skip");

	// Decrement subtracts one and skips exactly on fifteen
	property p_dec_val;
		@(posedge clk_sys) disable iff (reset)
		is_dec |=> (idx_r == $past(idx_r) - IDG_IDX_ONE) && (skip_r == (idx_r == IDG_IDX_WRAP));
	endproperty
	a_dec_val: assert property (p_dec_val) else $error("bad decrement");

	// No skip request without a decrement
	property p_no_skip;
		@(posedge clk_sys) disable iff (reset)
		!is_dec |=> !skip_r;
	endproperty
	a_no_skip: assert property (p_no_skip) else $error("stray skip");

	// Disable clears the flag, acceptance drops a cycle later
	property p_dis;
		@(posedge clk_sys) disable iff (reset)
		is_dis |=> !ie_r ##1 (!acc_r || $past(is_en));
	endproperty
	a_dis: assert property (p_dis) else $error("disable failed");

	// Acceptance still open in the cycle after a disable
	property p_dis_late;
		@(posedge clk_sys) disable iff (reset)
		ie_r && is_dis && !is_en |=> acc_r;
	endproperty
	a_dis_late: assert property (p_dis_late) else $error("disable too early");

	// Enable opens flag and acceptance at once
	property p_en;
		@(posedge clk_sys) disable iff (reset)
		is_en |=> ie_r && acc_r;
	endproperty
	a_en: assert property (p_en) else $error("enable failed");

	// Restart right after arming halts the watchdog
	property p_halt;
		@(posedge clk_sys) disable iff (reset)
		is_arm ##1 (is_rst && !is_arm) |=> halt_r && !rp_r;
	endproperty
	a_halt: assert property (p_halt) else $error("watchdog not halted");

	// A halted watchdog stays halted until reset
	property p_halt_sticky;
		@(posedge clk_sys) disable iff (reset)
		halt_r |=> halt_r;
	endproperty
	a_halt_sticky: assert property (p_halt_sticky) else $error("watchdog halt lost");

	// Restart without arming only pulses
	property p_plain_rst;
		@(posedge clk_sys) disable iff (reset)
		is_rst && !arm_r |=> rp_r && (halt_r == $past(halt_r));
	endproperty
	a_plain_rst: assert property (p_plain_rst) else $error("restart misbehaved");

	// Carry passes through untouched
	property p_carry;
		@(posedge clk_sys) disable iff (reset)
		op_valid |=> carry_flag == $past(carry_in);
	endproperty
	a_carry: assert property (p_carry) else $error("carry altered");

	// ==========================================
	// Cover points for the main scenarios
	c_wrap: cover property (@(posedge clk_sys) disable iff (reset) is_dec ##1 skip_r);
	c_dis: cover property (@(posedge clk_sys) disable iff (reset) ie_r && is_dis ##2 !acc_r);
	c_halt: cover property (@(posedge clk_sys) disable iff (reset) is_arm ##[1:4] is_rst);
	c_dis_en: cover property (@(posedge clk_sys) disable iff (reset) is_dis ##1 is_en ##1 acc_r);
	c_restart: cover property (@(posedge clk_sys) disable iff (reset) is_rst && !arm_r ##1 rp_r);
endmodule
`default_nettype wire

// File: logic/idg_pkg.sv
`default_nettype none
package idg_pkg;
	// ==========================================
	// Widths
	localparam int IDG_OP_W = 10;
	localparam int IDG_IDX_W = 4;
	// ==========================================
	// Opcodes (ten-bit words)
	localparam logic [9:0] IDG_OP_DEC_INDEX = 10'h017;
	localparam logic [9:0] IDG_OP_IRQ_DIS = 10'h004;
	localparam logic [9:0] IDG_OP_IRQ_EN = 10'h005;
	localparam logic [9:0] IDG_OP_WDT_ARM = 10'h29c;
	localparam logic [9:0] IDG_OP_WDT_RESTART = 10'h2a1;
	// ==========================================
	// Values
	localparam logic [3:0] IDG_IDX_WRAP = 4'hf;
	localparam logic [3:0] IDG_IDX_RESET = 4'h0;
	localparam logic [3:0] IDG_IDX_ONE = 4'h1;
	localparam logic IDG_IRQ_EN_RESET = 1'b0;
endpackage
`default_nettype wire

// File: verif/test_index_decrement_interrupt_gate_ops.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Compare and count
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_index_decrement_interrupt_gate_ops
	import idg_pkg::*;
;
	// Inputs
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic op_valid = 1'b0;
	logic [9:0] op_code = 10'h000;
	logic index_load = 1'b0;
	logic [3:0] index_load_val = 4'h0;
	logic carry_in = 1'b0;
	// Outputs
	logic [3:0] index_reg;
	logic skip_next, master_irq_enable_flag, irq_accept_en, wdt_stop_armed;
	logic wdt_halt, wdt_restart_pulse, carry_flag;
	// Model state, notes and counters
	logic [3:0] m_idx = 4'h0;
	logic m_flag = 1'b0, m_acc = 1'b0, m_arm = 1'b0, m_halt = 1'b0;
	logic [10:0] notes [$];
	logic [10:0] note_exp;
	logic [10:0] note_got;
	logic [15:0] lfsr = 16'h002d;
	logic [9:0] ops [6] = '{IDG_OP_DEC_INDEX, IDG_OP_IRQ_DIS, IDG_OP_IRQ_EN,
		IDG_OP_WDT_ARM, IDG_OP_WDT_RESTART, 10'h3ff};
	int mismatches = 0, compares = 0;
	idg_index_irq_gate idg_index_irq_gate_i (.clk_sys(clk_sys), .reset(reset),
		.op_valid(op_valid), .op_code(op_code), .index_load(index_load),
		.index_load_val(index_load_val), .carry_in(carry_in), .index_reg(index_reg),
		.skip_next(skip_next), .master_irq_enable_flag(master_irq_enable_flag),
		.irq_accept_en(irq_accept_en), .wdt_stop_armed(wdt_stop_armed),
		.wdt_halt(wdt_halt), .wdt_restart_pulse(wdt_restart_pulse), .carry_flag(carry_flag));
	// Clock
	always #12.5 clk_sys = ~clk_sys;
	// Drive one cycle at the falling edge and note what must follow
	task automatic step(input logic v, input logic [9:0] c, input logic ld,
		input logic [3:0] lv, input logic cy);
		logic sk, rp;
		@(negedge clk_sys);
		op_valid = v;
		op_code = c;
		index_load = ld;
		index_load_val = lv;
		carry_in = cy;
		sk = 1'b0;
		rp = 1'b0;
		// Decrement beats a load; wrap to fifteen asks for a skip
		if (v && c === IDG_OP_DEC_INDEX) begin
			m_idx = m_idx - 4'h1;
			sk = (m_idx === IDG_IDX_WRAP);
		end else if (ld) begin
			m_idx = lv;
		end
		// Acceptance follows the old flag a cycle late, except on enable
		if (v && c === IDG_OP_IRQ_EN) m_acc = 1'b1;
		else m_acc = m_flag;
		if (v && c === IDG_OP_IRQ_DIS) m_flag = 1'b0;
		if (v && c === IDG_OP_IRQ_EN) m_flag = 1'b1;
		// Restart halts once armed, else it restarts
		if (v && c === IDG_OP_WDT_RESTART) begin
			if (m_arm) m_halt = 1'b1;
			else rp = 1'b1;
		end
		if (v && c === IDG_OP_WDT_ARM) m_arm = 1'b1;
		notes.push_back({m_idx, sk, m_flag, m_acc, m_arm, m_halt, rp, cy});
	endtask
	// Watch outputs after each rising edge
	always @(posedge clk_sys) begin
		#1;
		if (notes.size() > 0) begin
			note_exp = notes.pop_front();
			note_got = {index_reg, skip_next, master_irq_enable_flag, irq_accept_en,
				wdt_stop_armed, wdt_halt, wdt_restart_pulse, carry_flag};
			`CHK(note_got, note_exp)
		end
	end
	// Next value of the stimulus shift register
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Verdict
	task automatic end_of_test();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(negedge clk_sys);
		reset = 1'b0;
		// Wrap from zero, decrement over load, load one then decrement to zero and wrap back to back
		step(1, IDG_OP_DEC_INDEX, 0, 4'h0, 1);
		step(1, IDG_OP_DEC_INDEX, 1, 4'h5, 0);
		step(0, IDG_OP_DEC_INDEX, 1, 4'h1, 1);
		step(1, IDG_OP_DEC_INDEX, 0, 4'h0, 0);
		step(1, IDG_OP_DEC_INDEX, 0, 4'h0, 1);
		$display("test index done");
		// Disable, enable back to back three times, idle, unknown code
		foreach (ops[i]) step(1, ops[(i % 2) + 1], 0, 4'h0, i[0]);
		step(0, 10'h000, 0, 4'h0, 0);
		step(1, 10'h3ff, 0, 4'h0, 1);
		$display("test irq done");
		// Restart unarmed twice, then arm and restart twice
		foreach (ops[i]) step(1, ops[(i < 2) ? 4 : 3 + i[0]], 0, 4'h0, 0);
		$display("test watchdog done");
		// Random traffic
		repeat (300) begin
			lfsr = lfsr_next(lfsr);
			step(lfsr[0], ops[lfsr[6:4] % 6], lfsr[1], lfsr[11:8], lfsr[2]);
		end
		$display("test random done");
		for (int i = 0; i < 4 && notes.size() > 0; i++) @(posedge clk_sys);
		@(negedge clk_sys);
		if (notes.size() != 0) mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
